/* File: gcm_defs.svh */
// Register offsets, field positions, reset values and timing counts of the clock selector
`ifndef GCM_DEFS_SVH
`define GCM_DEFS_SVH

`define GCM_OFS_CTRL 12'h000
`define GCM_OFS_FORCE 12'h004
`define GCM_OFS_STATUS 12'h008

`define GCM_BIT_SEL 0
`define GCM_BIT_GATE_LO 1
`define GCM_BIT_GATE_HI 2
`define GCM_BIT_DIS_LVL 3
`define GCM_BIT_SLEEP_N 4
`define GCM_BIT_STRB 0
`define GCM_BIT_PARKED 1
`define GCM_BIT_SWITCHING 2

`define GCM_CTRL_RESET 5'h10
`define GCM_NUM_OUT 10
`define GCM_MAX_EDGES 2'h3

`define GCM_RESP_OKAY 2'h0
`define GCM_RESP_DECERR 2'h3

`endif

/* File: gcm_pkg.sv */
// Types shared by the clock selector
package gcm_pkg;

	typedef struct packed {
		logic sleep_control_n;
		logic disable_level;
		logic gate_bank_high;
		logic gate_bank_low;
		logic input_select;
	} gcm_ctrl_t;

	typedef enum logic [1:0] {
		GCM_RUN,
		GCM_PARK_OLD,
		GCM_WAIT_NEW
	} gcm_state_t;

	typedef struct packed {
		logic [11:0] addr;
		logic full;
	} gcm_addr_hold_t;

endpackage

/* File: gcm_clock_mux.sv */
// Glitchless two-input clock selector with ten gated differential outputs
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "gcm_defs.svh"

module gcm_clock_mux #(
	parameter int NUM_OUT = `GCM_NUM_OUT
) (
	// System clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// Source clocks from pins
	input wire logic CLK_IN1,
	input wire logic CLK_IN2,
	// Differential outputs
	output logic [NUM_OUT-1:0] Q_TRUE,
	output logic [NUM_OUT-1:0] Q_COMP,
	// AXI4-Lite write address and data
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// AXI4-Lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);

	localparam int HALF = NUM_OUT / 2;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: first stage feeds only the second
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] clk_lvl;
	logic [1:0] clk_prev;

	// Three flops per clock, plus one more for edge detection
	always_ff @(posedge CLK_SYS) begin
		sync_a <= {CLK_IN2, CLK_IN1};
		sync_b <= sync_a;
		clk_lvl <= sync_b;
		clk_prev <= clk_lvl;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file over AXI4-Lite
	gcm_pkg::gcm_ctrl_t ctrl, next_ctrl;
	gcm_pkg::gcm_addr_hold_t aw_hold, next_aw_hold;
	logic w_full, next_w_full;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic force_bit, next_force_bit;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic do_write;
	gcm_pkg::gcm_state_t state, next_state;
	logic cur_sel, next_cur_sel;
	logic gate_en, next_gate_en;
	logic [1:0] edge_cnt, next_edge_cnt;

	// Write takes address and data in either order, then one response
	always_comb begin
		next_ctrl = ctrl;
		next_aw_hold = aw_hold;
		next_w_full = w_full;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_force_bit = force_bit;
		next_bvalid = BVALID;
		next_bresp = BRESP;
		if (AWVALID && AWREADY) begin
			next_aw_hold.full = 1'b1;
			next_aw_hold.addr = AWADDR;
		end
		if (WVALID && WREADY) begin
			next_w_full = 1'b1;
			next_w_data = WDATA;
			next_w_strb = WSTRB;
		end
		if (BVALID && BREADY) begin
			next_bvalid = 1'b0;
		end
		do_write = aw_hold.full && w_full && !BVALID;
		if (do_write) begin
			next_aw_hold.full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `GCM_RESP_OKAY;
			case (aw_hold.addr)
				`GCM_OFS_CTRL: begin
					if (w_strb[0]) begin
						next_ctrl = w_data[4:0];
					end
				end
				`GCM_OFS_FORCE: begin
					if (w_strb[0]) begin
						next_force_bit = w_data[`GCM_BIT_STRB];
					end
				end
				`GCM_OFS_STATUS: ;
				default: next_bresp = `GCM_RESP_DECERR;
			endcase
		end
		// Ready drops while a word is held so nothing is overwritten
		next_awready = !next_aw_hold.full && !next_bvalid;
		next_wready = !next_w_full && !next_bvalid;
	end

	// Read answers one cycle after the address is taken
	always_comb begin
		next_rvalid = RVALID;
		next_rdata = RDATA;
		next_rresp = RRESP;
		if (RVALID && RREADY) begin
			next_rvalid = 1'b0;
		end
		if (ARVALID && ARREADY) begin
			next_rvalid = 1'b1;
			next_rresp = `GCM_RESP_OKAY;
			case (ARADDR)
				`GCM_OFS_CTRL: next_rdata = {27'h0000000, ctrl};
				`GCM_OFS_FORCE: next_rdata = {31'h00000000, force_bit};
				`GCM_OFS_STATUS: next_rdata = {29'h00000000,
					state != gcm_pkg::GCM_RUN, !gate_en, cur_sel};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `GCM_RESP_DECERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	// Register stage of the bus slave
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			ctrl <= `GCM_CTRL_RESET;
			aw_hold <= '0;
			w_full <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			force_bit <= 1'b0;
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= 2'h0;
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= 2'h0;
		end else begin
			ctrl <= next_ctrl;
			aw_hold <= next_aw_hold;
			w_full <= next_w_full;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			force_bit <= next_force_bit;
			AWREADY <= next_awready;
			WREADY <= next_wready;
			BVALID <= next_bvalid;
			BRESP <= next_bresp;
			ARREADY <= next_arready;
			RVALID <= next_rvalid;
			RDATA <= next_rdata;
			RRESP <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Change-over state machine
	logic force_prev;
	logic force_rise;
	logic old_lvl, old_rise, new_lvl, new_rise;

	// Select low picks the second source
	always_comb begin
		old_lvl = cur_sel ? clk_lvl[0] : clk_lvl[1];
		old_rise = cur_sel ? (clk_lvl[0] && !clk_prev[0]) : (clk_lvl[1] && !clk_prev[1]);
		new_lvl = ctrl.input_select ? clk_lvl[0] : clk_lvl[1];
		new_rise = ctrl.input_select ? (clk_lvl[0] && !clk_prev[0])
			: (clk_lvl[1] && !clk_prev[1]);
		force_rise = force_bit && !force_prev;
	end

	// Next state; gating changes only while the clock is low, so no runt, except on a forced strobe or sleep
	always_comb begin
		next_state = state;
		next_cur_sel = cur_sel;
		next_gate_en = gate_en;
		next_edge_cnt = edge_cnt;
		case (state)
			gcm_pkg::GCM_RUN: begin
				if (ctrl.input_select != cur_sel) begin
					next_state = gcm_pkg::GCM_PARK_OLD;
					next_edge_cnt = 2'h0;
				end
			end
			gcm_pkg::GCM_PARK_OLD: begin
				// Park at the first low phase of the old clock
				if (!old_lvl) begin
					next_gate_en = 1'b0;
					next_cur_sel = ctrl.input_select;
					next_state = gcm_pkg::GCM_WAIT_NEW;
					next_edge_cnt = 2'h0;
				end else if (old_rise && edge_cnt != `GCM_MAX_EDGES) begin
					next_edge_cnt = edge_cnt + 2'h1;
				end
			end
			gcm_pkg::GCM_WAIT_NEW: begin
				// Resume on the low phase after one full new-clock edge
				if (edge_cnt != 2'h0 && !old_lvl) begin
					next_gate_en = 1'b1;
					next_state = gcm_pkg::GCM_RUN;
				end else if (old_rise && edge_cnt != `GCM_MAX_EDGES) begin
					next_edge_cnt = edge_cnt + 2'h1;
				end
				// A dead new clock never counts, so the outputs stay parked
				if (ctrl.input_select != cur_sel) begin
					next_cur_sel = ctrl.input_select;
					next_edge_cnt = 2'h0;
				end
			end
			default: begin
				next_state = gcm_pkg::GCM_RUN;
			end
		endcase
		// Forcing skips a possibly dead old clock entirely
		if (force_rise) begin
			next_gate_en = 1'b0;
			next_cur_sel = ctrl.input_select;
			next_state = gcm_pkg::GCM_WAIT_NEW;
			next_edge_cnt = 2'h0;
		end
		// Sleep freezes the selector parked; wake restarts cleanly
		if (!ctrl.sleep_control_n) begin
			next_gate_en = 1'b0;
			next_cur_sel = ctrl.input_select;
			next_state = gcm_pkg::GCM_WAIT_NEW;
			next_edge_cnt = 2'h0;
		end
	end

	// State registers
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			state <= gcm_pkg::GCM_WAIT_NEW;
			cur_sel <= 1'b0;
			gate_en <= 1'b0;
			edge_cnt <= 2'h0;
			force_prev <= 1'b0;
		end else begin
			state <= next_state;
			cur_sel <= next_cur_sel;
			gate_en <= next_gate_en;
			edge_cnt <= next_edge_cnt;
			force_prev <= force_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output fan-out with per-bank gating
	logic [NUM_OUT-1:0] next_q_true, next_q_comp;
	logic mux_clk;

	// Gates act on the very next edge, without waiting for a clock phase
	always_comb begin
		mux_clk = gate_en && old_lvl;
		for (int i = 0; i < NUM_OUT; i++) begin
			if (!ctrl.sleep_control_n) begin
				next_q_true[i] = 1'b1;
				next_q_comp[i] = 1'b1;
			end else if ((i < HALF) ? ctrl.gate_bank_low : ctrl.gate_bank_high) begin
				next_q_true[i] = ctrl.disable_level;
				next_q_comp[i] = !ctrl.disable_level;
			end else begin
				next_q_true[i] = mux_clk;
				next_q_comp[i] = !mux_clk;
			end
		end
	end

	// Output flops
	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			Q_TRUE <= '0;
			Q_COMP <= '1;
		end else begin
			Q_TRUE <= next_q_true;
			Q_COMP <= next_q_comp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	a_park_bound: assert property (state == gcm_pkg::GCM_PARK_OLD |-> edge_cnt != 2'h3)
		else $error("park took too many old clock cycles");
	a_park_low: assert property (state == gcm_pkg::GCM_WAIT_NEW && ctrl.sleep_control_n
		&& !ctrl.gate_bank_low |=> Q_TRUE[0] == 1'b0)
		else $error("output toggled while parked");
	a_resume_phase: assert property ($rose(gate_en) |-> !old_lvl)
		else $error("resume inside a high phase");
	a_bank_low: assert property (ctrl.sleep_control_n && ctrl.gate_bank_low
		|=> Q_TRUE[0] == $past(ctrl.disable_level) && Q_COMP[0] != Q_TRUE[0])
		else $error("low bank not at disable level");
	a_bank_high: assert property (ctrl.sleep_control_n && ctrl.gate_bank_high
		|=> Q_TRUE[NUM_OUT-1] == $past(ctrl.disable_level))
		else $error("high bank not at disable level");
	a_sleep_high: assert property (!ctrl.sleep_control_n |=> Q_TRUE == '1 && Q_COMP == '1)
		else $error("sleep outputs not high");
	a_force_park: assert property (force_rise && ctrl.sleep_control_n
		|=> state == gcm_pkg::GCM_WAIT_NEW && cur_sel == $past(ctrl.input_select))
		else $error("forced selection not taken");
	a_route_sel: assert property (state == gcm_pkg::GCM_RUN && gate_en && ctrl.sleep_control_n
		&& !ctrl.gate_bank_low
		|=> Q_TRUE[0] == ($past(cur_sel) ? $past(clk_lvl[0]) : $past(clk_lvl[1])))
		else $error("wrong source routed");
	a_fanout: assert property (ctrl.sleep_control_n && !ctrl.gate_bank_low
		&& !ctrl.gate_bank_high |=> Q_TRUE == {NUM_OUT{$past(mux_clk)}}
		&& Q_COMP == ~Q_TRUE)
		else $error("fan-out pairs disagree");
	a_dead_parked: assert property (state == gcm_pkg::GCM_WAIT_NEW && !force_rise
		&& edge_cnt == 2'h0 && !old_rise |=> !gate_en)
		else $error("resumed without a new clock edge");

	c_switch: cover property (state == gcm_pkg::GCM_PARK_OLD ##[1:40] $rose(gate_en));
	c_force: cover property (force_rise);
	c_sleep: cover property ($fell(ctrl.sleep_control_n));
	c_write: cover property (do_write);

endmodule

/* File: gcm_src_model.sv */
// Behavioural upstream clock source that can run or stand at a DC level
`timescale 1ns/1ps

module gcm_src_model #(
	parameter int HALF_NS = 44
) (
	// Clock towards the selector
	output logic CLK,
	// Run control and stuck level
	input wire logic RUN,
	input wire logic STUCK
);
	initial CLK = 1'b0;

	// Stopping freezes at the commanded level, a dead source or DC fault
	always begin
		#(HALF_NS);
		CLK = RUN ? ~CLK : STUCK;
	end
endmodule

/* File: gcm_testbench.sv */
// Self-checking bench for the glitchless clock selector
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end

module testbench;
	logic CLK_SYS = 1'b0, RESETN = 1'b0, run1 = 1'b1, run2 = 1'b1, lvl2 = 1'b0;
	logic CLK_IN1, CLK_IN2, AWREADY, WREADY, BVALID, ARREADY, RVALID, pair_on = 1'b0;
	logic [9:0] Q_TRUE, Q_COMP;
	logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
	logic [31:0] WDATA = 32'h0, RDATA, rd;
	logic [3:0] WSTRB = 4'hf;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [1:0] BRESP, RRESP, rr;
	int bad_count = 0, compares = 0, ris_lo, ris_hi, low_run, max_low, high_run, min_high;
	int pair_err = 0, mdl_ctrl, i, r, c;

	always #4 CLK_SYS = ~CLK_SYS;

	gcm_src_model #(.HALF_NS(100)) src1_u (.CLK(CLK_IN1), .RUN(run1), .STUCK(1'b0));
	gcm_src_model #(.HALF_NS(44)) src2_u (.CLK(CLK_IN2), .RUN(run2), .STUCK(lvl2));
	gcm_clock_mux dut_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CLK_IN1(CLK_IN1),
		.CLK_IN2(CLK_IN2), .Q_TRUE(Q_TRUE), .Q_COMP(Q_COMP), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

	////////////////////////////////////////////////////////////////////////////////
	// Output edge counts of pairs one and ten, run lengths of pair one
	always @(posedge Q_TRUE[0]) ris_lo++;
	always @(posedge Q_TRUE[9]) ris_hi++;
	always @(posedge CLK_SYS) begin
		if (Q_TRUE[0]) high_run++;
		else begin
			if (high_run > 0 && high_run < min_high) min_high = high_run;
			high_run = 0;
		end
		low_run = Q_TRUE[0] ? 0 : low_run + 1;
		if (low_run > max_low) max_low = low_run;
		if (pair_on && Q_COMP !== ~Q_TRUE) pair_err++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus master tasks, sampling before the edge's own updates land
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		int n;
		@(posedge CLK_SYS);
		AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1;
		aw = 1'b1; w = 1'b1; n = 0;
		while ((aw || w) && n < 100) begin
			@(posedge CLK_SYS);
			if (aw && AWREADY) begin aw = 1'b0; AWVALID <= 1'b0; end
			if (w && WREADY) begin w = 1'b0; WVALID <= 1'b0; end
			n++;
		end
		BREADY <= 1'b1;
		do begin @(posedge CLK_SYS); n++; end while (!BVALID && n < 200);
		BREADY <= 1'b0;
		`CHK("bvalid", 1'b1, BVALID)
		`CHK("bresp", er, BRESP)
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge CLK_SYS);
		ARADDR <= a; ARVALID <= 1'b1; n = 0;
		do begin @(posedge CLK_SYS); n++; end while (!ARREADY && n < 100);
		ARVALID <= 1'b0; RREADY <= 1'b1;
		do begin @(posedge CLK_SYS); n++; end while (!RVALID && n < 200);
		d = RDATA; rs = RRESP;
		RREADY <= 1'b0;
		`CHK("rvalid", 1'b1, RVALID)
	endtask

	// Model write of the control word, then let the outputs follow
	task automatic wc(input int v);
		mdl_ctrl = v;
		axw(12'h000, v, 2'h0);
		repeat (4) @(posedge CLK_SYS);
	endtask

	task automatic win(input int ns);
		ris_lo = 0; ris_hi = 0; max_low = 0; low_run = 0; min_high = 999; high_run = -100;
		#(ns);
	endtask

	// Tolerance of two edges covers window phase and sync lag
	task automatic rate(input int e, input int got);
		`CHK("rate", 1'b1, (got >= e - 2 && got <= e + 2))
	endtask

	task automatic stop_test;
		$display("counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(32'ha745));
		repeat (16) @(posedge CLK_SYS);
		RESETN <= 1'b1;
		axr(12'h000, rd, rr);
		`CHK("ctrl_reset", 32'h10, rd)
		axr(12'h00c, rd, rr);
		`CHK("unmapped_resp", 2'h3, rr)
		`CHK("unmapped_data", 32'h0, rd)
		axw(12'h00c, 32'h1f, 2'h3);
		axr(12'h000, rd, rr);
		`CHK("ctrl_kept", 32'h10, rd)
		$display("done registers");
		mdl_ctrl = 32'h10;
		#2000;
		pair_on = 1'b1;
		win(8800);
		rate(100, ris_lo);
		rate(100, ris_hi);
		// Switch to the first source and back, tracking park time and pulses
		for (i = 0; i < 2; i++) begin
			win(0);
			wc(i ? 32'h10 : 32'h11);
			#3000;
			`CHK("park_time", 1'b1, max_low <= 120)
			`CHK("no_runt", 1'b1, min_high >= 4)
			win(8800);
			rate(i ? 100 : 44, ris_lo);
		end
		$display("done switching");
		// Every gate and level mix, in turn from a random start
		r = $urandom % 8;
		for (i = 0; i < 8; i++) begin
			c = 32'h10 | (((i + r) % 8) << 1);
			wc(c);
			axr(12'h000, rd, rr);
			`CHK("ctrl_readback", mdl_ctrl, rd)
			win(1760);
			if (c[1]) `CHK("bank_lo", {5{c[3]}}, Q_TRUE[4:0])
			else rate(20, ris_lo);
			if (c[2]) `CHK("bank_hi_n", ~{5{c[3]}}, Q_COMP[9:5])
			else rate(20, ris_hi);
		end
		$display("done gating");
		// Old source stuck high: only the forced strobe or sleep frees the change-over
		wc(32'h10);
		lvl2 = 1'b1;
		run2 = 1'b0;
		#500;
		wc(32'h11);
		#2000;
		axw(12'h004, 32'h1, 2'h0);
		#3000;
		axr(12'h004, rd, rr);
		`CHK("force_readback", 32'h1, rd)
		win(8800);
		rate(44, ris_lo);
		axw(12'h004, 32'h0, 2'h0);
		$display("done forcing");
		// New source dead: outputs must stay parked
		lvl2 = 1'b0;
		#500;
		wc(32'h10);
		#2000;
		win(4000);
		`CHK("dead_rises", 0, ris_lo)
		`CHK("dead_parked", 10'h000, Q_TRUE)
		axr(12'h008, rd, rr);
		`CHK("dead_status", 32'h6, rd)
		run2 = 1'b1;
		#2000;
		win(8800);
		rate(100, ris_lo);
		$display("done dead source");
		// Gate off before sleep, wake, then release the gates
		wc(32'h16);
		pair_on = 1'b0;
		wc(32'h06);
		`CHK("sleep_true", 10'h3ff, Q_TRUE)
		`CHK("sleep_comp", 10'h3ff, Q_COMP)
		wc(32'h16);
		#3000;
		wc(32'h10);
		pair_on = 1'b1;
		win(1760);
		rate(20, ris_lo);
		`CHK("pairing", 0, pair_err)
		$display("done sleep");
		stop_test();
	end
endmodule
